// File: rtl/pia_pkg.sv
`default_nettype none
package pia_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int NUM_TS = 32;
  localparam int NUM_BUNDLES = 64;
  localparam int HALF_BUNDLES = 32;
  localparam int NUM_SINGLE = 2;
  localparam int NUM_MAC = 8;
  localparam int NUM_FIELDS = 4;
  localparam int PEND_W = 10;

  // ---------------------------------------------------------------
  // pending register bit positions
  // ---------------------------------------------------------------
  localparam int PB_SINGLE = 0;
  localparam int PB_MAC = 2;
  localparam int PB_CW = 3;
  localparam int PB_RX = 4;
  localparam int PB_TX = 6;
  localparam int PB_UR = 8;

  // global status / mask bit
  localparam int CORE_BIT = 24;

  // control word field order in field select and event vectors
  localparam int FLD_L = 0;
  localparam int FLD_R = 1;
  localparam int FLD_M = 2;
  localparam int FLD_FRAG = 3;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_GLOBAL_STATUS = 8'h00;
  localparam logic [7:0] A_GLOBAL_MASK = 8'h04;
  localparam logic [7:0] A_PENDING = 8'h08;
  localparam logic [7:0] A_PEND_MASK = 8'h0c;
  localparam logic [7:0] A_FIELD_SEL = 8'h10;
  localparam logic [7:0] A_MAC_CAUSE = 8'h14;
  localparam logic [7:0] A_CW_LOWER = 8'h18;
  localparam logic [7:0] A_CW_UPPER = 8'h1c;
  localparam logic [7:0] A_CW_BMASK_LO = 8'h20;
  localparam logic [7:0] A_CW_BMASK_HI = 8'h24;
  // per-port block: base + port * stride, port index in bit 5
  localparam logic [7:0] A_PORT_BASE = 8'h40;
  localparam logic [7:0] A_PORT_END = 8'h7f;
  localparam logic [4:0] PO_RX_CHG = 5'h00;
  localparam logic [4:0] PO_TX_CHG = 5'h04;
  localparam logic [4:0] PO_TX_MASK = 5'h08;
  localparam logic [4:0] PO_UR = 5'h0c;
  localparam logic [4:0] PO_UR_MASK = 5'h10;

  // ---------------------------------------------------------------
  // reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [PEND_W-1:0] PEND_MASK_RST = 10'h3ff;
  localparam logic [NUM_FIELDS-1:0] FIELD_SEL_RST = 4'hf;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pia_pkg
`default_nettype wire

// File: rtl/pia_sticky.sv
`default_nettype none
module pia_sticky #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and clears
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  // held flags
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] next_flags;

  // a set arriving with its clear wins, so no event is lost
  always_comb begin
    next_flags = (flags & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : pia_sticky
`default_nettype wire

// File: rtl/pia_aggregator.sv
`default_nettype none
// How it works
// - one interrupt output pin carries every outstanding request to the host
// - only pseudowire core events, MAC included, feed the interrupt pin
// - core requests reach the pin only while global mask bit is one
// - pending bits stay set until software writes one; zero does nothing
// - pending mask resets to all ones so nothing interrupts after reset
// - mask bit zero enables its pending bit, one keeps it masked
// - pending holds single-event bits and summary bits of several sources
// - underrun and transmit signalling events have per-timeslot masks
// - control word changes masked per bundle; field select picks L,R,M,frag
// - pending has one rx, one tx and one underrun bit per port
// - per-port rx signalling-change flags per timeslot, cleared by writing one
// - per-port tx signalling-change flags per timeslot, write one to clear
// - lower and upper bundle sets flag control word changes, write one clears
// - per-port underrun flags per jitter buffer, write one to clear
// - reading the mac cause register clears all its bits
// - masked pending bit interrupts at once when its mask is cleared
// - global status bit 24 shows core request regardless of global mask
module pia_aggregator
  import pia_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core event pulses
  input wire logic [NUM_SINGLE-1:0] single_evt,
  input wire logic [NUM_MAC-1:0] mac_irq_source,
  input wire logic control_word_change,
  input wire logic [5:0] cw_bundle,
  input wire logic [NUM_FIELDS-1:0] cw_fields,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] rx_sig_change,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] tx_sig_change,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] jitter_buffer_underrun,
  // host interrupt pin, active high
  output logic host_irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic core_block_irq_mask_bit, next_core_block_irq_mask_bit;
  logic [PEND_W-1:0] pend_mask, next_pend_mask;
  logic [NUM_FIELDS-1:0] control_word_field_select, next_control_word_field_select;
  logic [NUM_BUNDLES-1:0] control_word_bundle_mask, next_control_word_bundle_mask;
  logic [NUM_TS-1:0] tx_ts_mask [NUM_PORTS], next_tx_ts_mask [NUM_PORTS];
  logic [NUM_TS-1:0] underrun_timeslot_mask [NUM_PORTS], next_underrun_timeslot_mask [NUM_PORTS];
  logic [PEND_W-1:0] pending, pend_set, pend_clr;
  logic [NUM_MAC-1:0] mac_irq_cause_reg, mac_clr;
  logic [NUM_BUNDLES-1:0] cw_flags, cw_set, cw_clr;
  logic [NUM_TS-1:0] rx_flags [NUM_PORTS], tx_flags [NUM_PORTS], ur_flags [NUM_PORTS];
  logic [NUM_TS-1:0] rx_clr [NUM_PORTS], tx_clr [NUM_PORTS], ur_clr [NUM_PORTS];
  logic core_req, core_block_irq_status_bit, next_host_irq;

  // bus state
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0] wr_strb, next_wr_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word, wmask, w1c;
  logic rd_ok, wr_ok, wr_fire, rd_fire;

  // byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = ZERO32;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic in_port(input logic [7:0] a);
    return (a >= A_PORT_BASE) && (a <= A_PORT_END);
  endfunction : in_port

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wmask = lane_mask(wr_strb);
  assign w1c = wr_data & wmask;

  // ---------------------------------------------------------------
  // event collection
  // ---------------------------------------------------------------
  // control word event hits only for a selected field on an unmasked bundle
  always_comb begin
    cw_set = '0;
    if (control_word_change && |(cw_fields & control_word_field_select) &&
        !control_word_bundle_mask[cw_bundle]) begin
      cw_set[cw_bundle] = 1'b1;
    end
  end

  // summary and single-event sources of the pending register
  always_comb begin
    pend_set = '0;
    pend_set[PB_SINGLE +: NUM_SINGLE] = single_evt;
    pend_set[PB_MAC] = |mac_irq_source;
    pend_set[PB_CW] = |cw_set;
    for (int p = 0; p < NUM_PORTS; p++) begin
      pend_set[PB_RX + p] = |rx_sig_change[p];
      pend_set[PB_TX + p] = |(tx_sig_change[p] & ~tx_ts_mask[p]);
      pend_set[PB_UR + p] = |(jitter_buffer_underrun[p] & ~underrun_timeslot_mask[p]);
    end
  end

  // write-one-to-clear decode; writing zero leaves flags alone
  always_comb begin
    pend_clr = '0;
    cw_clr = '0;
    mac_clr = '0;
    if (wr_fire && wr_addr == A_PENDING) begin
      pend_clr = w1c[PEND_W-1:0];
    end
    if (wr_fire && wr_addr == A_CW_LOWER) begin
      cw_clr[0 +: HALF_BUNDLES] = w1c;
    end
    if (wr_fire && wr_addr == A_CW_UPPER) begin
      cw_clr[HALF_BUNDLES +: HALF_BUNDLES] = w1c;
    end
    // reading the cause register empties it
    if (rd_fire && s_axi_araddr == A_MAC_CAUSE) begin
      mac_clr = '1;
    end
  end

  pia_sticky #(.WIDTH(PEND_W)) u_pending (
    .clk(clk), .rst_n(rst_n), .set_vec(pend_set), .clr_vec(pend_clr), .flags(pending)
  );

  pia_sticky #(.WIDTH(NUM_MAC)) u_mac_cause (
    .clk(clk), .rst_n(rst_n), .set_vec(mac_irq_source), .clr_vec(mac_clr), .flags(mac_irq_cause_reg)
  );

  pia_sticky #(.WIDTH(NUM_BUNDLES)) u_cw_change (
    .clk(clk), .rst_n(rst_n), .set_vec(cw_set), .clr_vec(cw_clr), .flags(cw_flags)
  );

  // per-port timeslot flag banks
  for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
    logic sel;
    assign sel = wr_fire && in_port(wr_addr) && (wr_addr[5] == 1'(gp));
    assign rx_clr[gp] = (sel && wr_addr[4:0] == PO_RX_CHG) ? w1c : '0;
    assign tx_clr[gp] = (sel && wr_addr[4:0] == PO_TX_CHG) ? w1c : '0;
    assign ur_clr[gp] = (sel && wr_addr[4:0] == PO_UR) ? w1c : '0;

    pia_sticky #(.WIDTH(NUM_TS)) u_rx (
      .clk(clk), .rst_n(rst_n), .set_vec(rx_sig_change[gp]), .clr_vec(rx_clr[gp]), .flags(rx_flags[gp])
    );

    // masked timeslots are still recorded, but raise no summary bit
    pia_sticky #(.WIDTH(NUM_TS)) u_tx (
      .clk(clk), .rst_n(rst_n), .set_vec(tx_sig_change[gp]), .clr_vec(tx_clr[gp]), .flags(tx_flags[gp])
    );

    pia_sticky #(.WIDTH(NUM_TS)) u_ur (
      .clk(clk), .rst_n(rst_n), .set_vec(jitter_buffer_underrun[gp]), .clr_vec(ur_clr[gp]), .flags(ur_flags[gp])
    );
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  // level follows pending and mask, so unmasking a held bit fires at once
  assign core_req = |(pending & ~pend_mask);
  assign core_block_irq_status_bit = core_req;
  assign next_host_irq = core_req && core_block_irq_mask_bit;

  // ---------------------------------------------------------------
  // software-written control registers
  // ---------------------------------------------------------------
  always_comb begin
    next_core_block_irq_mask_bit = core_block_irq_mask_bit;
    next_pend_mask = pend_mask;
    next_control_word_field_select = control_word_field_select;
    next_control_word_bundle_mask = control_word_bundle_mask;
    next_tx_ts_mask = tx_ts_mask;
    next_underrun_timeslot_mask = underrun_timeslot_mask;
    if (wr_fire) begin
      case (wr_addr)
        A_GLOBAL_MASK: if (wmask[CORE_BIT]) next_core_block_irq_mask_bit = wr_data[CORE_BIT];
        A_PEND_MASK: next_pend_mask = (pend_mask & ~wmask[PEND_W-1:0]) | w1c[PEND_W-1:0];
        A_FIELD_SEL: next_control_word_field_select =
          (control_word_field_select & ~wmask[NUM_FIELDS-1:0]) | w1c[NUM_FIELDS-1:0];
        A_CW_BMASK_LO: next_control_word_bundle_mask[0 +: HALF_BUNDLES] =
          (control_word_bundle_mask[0 +: HALF_BUNDLES] & ~wmask) | w1c;
        A_CW_BMASK_HI: next_control_word_bundle_mask[HALF_BUNDLES +: HALF_BUNDLES] =
          (control_word_bundle_mask[HALF_BUNDLES +: HALF_BUNDLES] & ~wmask) | w1c;
        default: begin
          if (in_port(wr_addr) && wr_addr[4:0] == PO_TX_MASK) begin
            next_tx_ts_mask[wr_addr[5]] = (tx_ts_mask[wr_addr[5]] & ~wmask) | w1c;
          end
          if (in_port(wr_addr) && wr_addr[4:0] == PO_UR_MASK) begin
            next_underrun_timeslot_mask[wr_addr[5]] =
              (underrun_timeslot_mask[wr_addr[5]] & ~wmask) | w1c;
          end
        end
      endcase
    end
  end

  // every pending source starts masked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_block_irq_mask_bit <= 1'b0;
      pend_mask <= PEND_MASK_RST;
      control_word_field_select <= FIELD_SEL_RST;
      control_word_bundle_mask <= '0;
      tx_ts_mask <= '{default: '0};
      underrun_timeslot_mask <= '{default: '0};
      host_irq <= 1'b0;
    end else begin
      core_block_irq_mask_bit <= next_core_block_irq_mask_bit;
      pend_mask <= next_pend_mask;
      control_word_field_select <= next_control_word_field_select;
      control_word_bundle_mask <= next_control_word_bundle_mask;
      tx_ts_mask <= next_tx_ts_mask;
      underrun_timeslot_mask <= next_underrun_timeslot_mask;
      host_irq <= next_host_irq;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = ZERO32;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      A_GLOBAL_STATUS: rd_word[CORE_BIT] = core_block_irq_status_bit;
      A_GLOBAL_MASK: rd_word[CORE_BIT] = core_block_irq_mask_bit;
      A_PENDING: rd_word[PEND_W-1:0] = pending;
      A_PEND_MASK: rd_word[PEND_W-1:0] = pend_mask;
      A_FIELD_SEL: rd_word[NUM_FIELDS-1:0] = control_word_field_select;
      A_MAC_CAUSE: rd_word[NUM_MAC-1:0] = mac_irq_cause_reg;
      A_CW_LOWER: rd_word = cw_flags[0 +: HALF_BUNDLES];
      A_CW_UPPER: rd_word = cw_flags[HALF_BUNDLES +: HALF_BUNDLES];
      A_CW_BMASK_LO: rd_word = control_word_bundle_mask[0 +: HALF_BUNDLES];
      A_CW_BMASK_HI: rd_word = control_word_bundle_mask[HALF_BUNDLES +: HALF_BUNDLES];
      default: begin
        if (in_port(s_axi_araddr)) begin
          case (s_axi_araddr[4:0])
            PO_RX_CHG: rd_word = rx_flags[s_axi_araddr[5]];
            PO_TX_CHG: rd_word = tx_flags[s_axi_araddr[5]];
            PO_TX_MASK: rd_word = tx_ts_mask[s_axi_araddr[5]];
            PO_UR: rd_word = ur_flags[s_axi_araddr[5]];
            PO_UR_MASK: rd_word = underrun_timeslot_mask[s_axi_araddr[5]];
            default: rd_ok = 1'b0;
          endcase
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // unmapped writes are dropped and answered with an error
  always_comb begin
    wr_ok = 1'b1;
    case (wr_addr)
      A_GLOBAL_MASK, A_PENDING, A_PEND_MASK, A_FIELD_SEL, A_CW_LOWER, A_CW_UPPER,
      A_CW_BMASK_LO, A_CW_BMASK_HI: wr_ok = 1'b1;
      default: wr_ok = in_port(wr_addr) && (wr_addr[4:0] <= PO_UR_MASK) && (wr_addr[1:0] == 2'h0);
    endcase
  end

  // ---------------------------------------------------------------
  // axi4-lite handshakes
  // ---------------------------------------------------------------
  // address and data are taken in either order; ready drops until bresp is taken
  always_comb begin
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awready = 1'b0;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wready = 1'b0;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    // read data is captured on acceptance so the clear-on-read sees one snapshot
    if (rd_fire) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= ZERO32;
      wr_strb <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ZERO32;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : pia_aggregator
`default_nettype wire

// File: testbench/pia_aggregator_props.sv
`default_nettype none
module pia_props
  import pia_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // events and pin
  input wire logic [NUM_SINGLE-1:0] single_evt,
  input wire logic [NUM_MAC-1:0] mac_irq_source,
  input wire logic control_word_change,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] rx_sig_change,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] tx_sig_change,
  input wire logic [NUM_PORTS-1:0][NUM_TS-1:0] jitter_buffer_underrun,
  input wire logic host_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_HOLE = 8'h30;
  logic wrote, next_wrote, evt_any;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // any event input
  assign evt_any = (|single_evt) | (|mac_irq_source) | control_word_change | (|rx_sig_change)
    | (|tx_sig_change) | (|jitter_buffer_underrun);
  // masks reset closed: pin low until the first write
  always_comb next_wrote = wrote | (s_axi_awvalid & s_axi_awready);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wrote <= 1'b0;
    else wrote <= next_wrote;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_quiet_reset: assert property (!wrote |-> !host_irq)
    else $error("pin high before any write");
  a_rise_cause: assert property ($rose(host_irq) |-> $past(evt_any, 2) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin rose without cause");
  a_fall_cause: assert property ($fell(host_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin fell without write");
  a_status_bit: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_GLOBAL_STATUS
    && host_irq && !s_axi_bvalid |=> s_axi_rdata[CORE_BIT]) else $error("status bit low");
  a_hole_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_HOLE
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == ZERO32) else $error("hole read accepted");
  a_pend_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_PENDING
    |=> s_axi_rresp == RESP_OKAY) else $error("pending read not okay");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("aw reaccepted early");
  c_irq: cover property ($rose(host_irq));
  c_hole: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_HOLE);
  c_status: cover property (s_axi_rvalid && s_axi_rdata[CORE_BIT]);
endmodule : pia_props
`default_nettype wire

// File: testbench/pia_host.sv
`default_nettype none
module pia_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus before the first request
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // write: released payload shows its inverse so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  // read: answer data is taken by the bench's watcher at the same edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : pia_host
`default_nettype wire

// File: testbench/testbench.sv
`default_nettype none
module testbench
  import pia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, control_word_change, host_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mac_irq_source, m, a;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cw_fields, f;
  logic [1:0] s_axi_bresp, s_axi_rresp, single_evt;
  logic [5:0] cw_bundle, b;
  logic [4:0] off;
  logic [NUM_PORTS-1:0][NUM_TS-1:0] rx_sig_change, tx_sig_change, jitter_buffer_underrun;
  logic [33:0] qr[$];
  logic qp[$];
  event smp;
  int err_total = 0, n_tests = 0, cyc = 0, ts;
  pia_aggregator i_pia_aggregator (.*);
  pia_host i_pia_host (.*);
  // ------------------------------------------------------------
  // clock, timeout and checking
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask : cmp
  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // watchers take the oldest note whenever a result shows
  always @(posedge clk) if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, qr.pop_front());
  always @(smp) cmp({33'h0, host_irq}, {33'h0, qp.pop_front()});
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    qr.push_back({r, e});
    i_pia_host.rd(ad);
  endtask : rchk
  // pin settles one edge after a commit, so two edges is enough
  task automatic pin(input logic e);
    repeat (2) @(posedge clk);
    qp.push_back(e);
    #1 ->smp;
  endtask : pin
  // one-cycle event pulse on source i, timeslot t
  task automatic fire(input int i, input int t);
    @(posedge clk);
    case (i)
      0, 1: single_evt[i] <= 1'b1;
      2: mac_irq_source <= m;
      3: begin
        control_word_change <= 1'b1;
        cw_bundle <= b;
        cw_fields <= f;
      end
      4, 5: rx_sig_change[i-4][t] <= 1'b1;
      6, 7: tx_sig_change[i-6][t] <= 1'b1;
      default: jitter_buffer_underrun[i-8][t] <= 1'b1;
    endcase
    @(posedge clk);
    {single_evt, mac_irq_source, control_word_change} <= '0;
    {rx_sig_change, tx_sig_change, jitter_buffer_underrun} <= '0;
  endtask : fire
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {single_evt, mac_irq_source, control_word_change, cw_bundle, cw_fields} = '0;
    {rx_sig_change, tx_sig_change, jitter_buffer_underrun} = '0;
    void'($urandom(32'h7c8835f0));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_PEND_MASK, 32'(PEND_MASK_RST));
    rchk(A_FIELD_SEL, 32'(FIELD_SEL_RST));
    rchk(A_GLOBAL_MASK, ZERO32);
    rchk(8'h30, ZERO32, RESP_SLVERR);
    // masked pending bit, then unmasking raises the pin at once
    fire(0, 0);
    pin(1'b0);
    rchk(A_PENDING, 32'h1);
    i_pia_host.wr(A_GLOBAL_MASK, 32'h1 << CORE_BIT);
    pin(1'b0);
    i_pia_host.wr(A_PEND_MASK, 32'h3fe);
    pin(1'b1);
    rchk(A_GLOBAL_STATUS, 32'h1 << CORE_BIT);
    i_pia_host.wr(A_GLOBAL_MASK, ZERO32);
    pin(1'b0);
    rchk(A_GLOBAL_STATUS, 32'h1 << CORE_BIT);
    i_pia_host.wr(A_GLOBAL_MASK, 32'h1 << CORE_BIT);
    i_pia_host.wr(A_PENDING, ZERO32);
    pin(1'b1);
    i_pia_host.wr(A_PENDING, 32'h1);
    pin(1'b0);
    rchk(A_GLOBAL_STATUS, ZERO32);
    // every pending source, then its second-level flags
    for (int i = 0; i < PEND_W; i++) begin
      ts = $urandom_range(NUM_TS - 1);
      m = 8'($urandom_range(255, 1));
      b = 6'($urandom_range(63));
      f = 4'($urandom_range(15, 1));
      fire(i, ts);
      rchk(A_PENDING, 32'h1 << i);
      i_pia_host.wr(A_PENDING, 32'h1 << i);
      rchk(A_PENDING, ZERO32);
      if (i == PB_MAC) begin
        rchk(A_MAC_CAUSE, {24'h0, m});
        rchk(A_MAC_CAUSE, ZERO32);
      end else if (i >= PB_CW) begin
        off = (i < PB_TX) ? PO_RX_CHG : (i < PB_UR) ? PO_TX_CHG : PO_UR;
        a = A_PORT_BASE + {2'h0, i[0], 5'h0} + {3'h0, off};
        if (i == PB_CW) a = b[5] ? A_CW_UPPER : A_CW_LOWER;
        if (i == PB_CW) ts = int'(b[4:0]);
        rchk(a, 32'h1 << ts);
        i_pia_host.wr(a, 32'h1 << ts);
        rchk(a, ZERO32);
      end
    end
    // masked timeslots still flag per port but not the summary
    for (int k = 0; k < 2; k++) begin
      ts = $urandom_range(NUM_TS - 1);
      a = A_PORT_BASE + {2'h0, k[0], 5'h0};
      i_pia_host.wr(a + {3'h0, k ? PO_UR_MASK : PO_TX_MASK}, 32'h1 << ts);
      fire(k ? 9 : 6, ts);
      rchk(A_PENDING, ZERO32);
      rchk(a + {3'h0, k ? PO_UR : PO_TX_CHG}, 32'h1 << ts);
    end
    // each control word field alone selects the change event
    for (int k = 0; k < NUM_FIELDS; k++) begin
      b = 6'($urandom_range(31));
      i_pia_host.wr(A_FIELD_SEL, 32'h1 << k);
      f = 4'hf & ~(4'h1 << k);
      fire(3, 0);
      rchk(A_PENDING, ZERO32);
      f = 4'h1 << k;
      fire(3, 0);
      rchk(A_PENDING, 32'h1 << PB_CW);
      i_pia_host.wr(A_PENDING, 32'h1 << PB_CW);
    end
    // a masked bundle in the upper set stays silent
    i_pia_host.wr(A_FIELD_SEL, 32'hf);
    b = 6'(32 + $urandom_range(31));
    i_pia_host.wr(A_CW_BMASK_HI, 32'h1 << b[4:0]);
    fire(3, 0);
    rchk(A_PENDING, ZERO32);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : testbench
bind pia_aggregator pia_props i_pia_props (.*);
`default_nettype wire
